// ===== pcbp_pkg.sv
package pcbp_pkg;

  // ==========================================================
  // Commands and answer layout
  localparam logic [7:0] CMD_REQ = 8'h05;
  localparam logic [7:0] CMD_ATTR = 8'h1d;
  localparam logic [7:0] ATQB_HDR = 8'h50;
  localparam logic [7:0] AFC = 8'h00;
  localparam logic [15:0] AID_CRC = 16'h0000;
  localparam logic [7:0] APP_CNT = 8'h00;
  localparam logic [7:0] BIT_RATE = 8'h33;
  localparam logic [7:0] RATE_FC32 = 8'h22;
  localparam logic [3:0] FSCI = 4'h8;
  localparam logic [3:0] FSCI_MIN = 4'h8;
  localparam logic [3:0] PROT_TYPE = 4'h1;
  localparam logic [3:0] FWI_MAX = 4'hc;
  localparam logic [1:0] ADC = 2'h0;
  localparam logic [1:0] FOPT = 2'h1;
  localparam logic [3:0] MAX_BUFFER_LENGTH_INDEX = 4'h0;

  // ==========================================================
  // Block protocol
  localparam logic [7:0] PCB_WTX = 8'hfa;
  localparam int CID_FLAG = 3;
  localparam logic [7:0] CID_RSV = 8'h60;
  localparam logic [1:0] PLI = 2'h0;
  localparam logic [5:0] WAIT_EXTENSION_MULTIPLIER_MAX = 6'h3b;
  localparam logic [8:0] FRAME_MAX = 9'h100;
  localparam logic [8:0] CNT_SAT = 9'h101;

  // ==========================================================
  // Answer lengths and identifier generator
  localparam logic [3:0] ATQB_LEN = 4'hc;
  localparam logic [3:0] ATTR_LEN = 4'h1;
  localparam logic [3:0] WTX_LEN = 4'h3;
  localparam logic [31:0] PSEUDO_UNIQUE_CARD_ID_POLY = 32'h80200003;
  localparam logic [31:0] PSEUDO_UNIQUE_CARD_ID_INIT = 32'h00000001;

  // ==========================================================
  // Types
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } pcbp_byte_s;

  typedef enum logic [1:0] {
    LS_WAIT,
    LS_READY,
    LS_ACTIVE
  } pcbp_lst_e;

  typedef enum logic [1:0] {
    TK_ATQB,
    TK_ATTR,
    TK_WTX
  } pcbp_kind_e;

endpackage : pcbp_pkg

// ===== pcbp_profile.sv
`timescale 1ns/10ps

// How it works
// - First identifier after power-off differs from the previous session's one.
// - Answer carries application family code 00.
// - Application checksum and count are free values, nobody depends on them.
// - Bit-rate field advertises at least fc/32.
// - Frame size field says 256 bytes; receiver accepts up to 256.
// - Protocol type field announces the half-duplex block protocol.
// - Frame-wait exponent never above twelve.
// - Data coding field is zero, family code stays 00.
// - Frame option declares logical id, never node address.
// - ATTRIB answer reports no buffer length index.
// - Logical id bits 6-5 sent as zero; nonzero received is an error.
// - Extended wait never exceeds the exponent-twelve wait time.
// - Power level indication stays zero.
module pcbp_profile #(
  parameter logic [3:0] FRAME_WAIT_EXP = 4'hc
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkLink,
  input wire logic [31:0] pupiSeed,
  output logic [31:0] pupiStore,
  output logic pupiStoreWr,
  input wire logic wtxReq,
  input wire logic [5:0] wtxMult,
  output logic wtxBusy,
  output logic [5:0] wtxGranted,
  output logic protoErr,
  output logic sessionActive,
  input wire pcbp_pkg::pcbp_byte_s lnkRx,
  output pcbp_pkg::pcbp_byte_s lnkTx,
  input wire logic lnkTxReady
);

  // ==========================================================
  // Elaboration checks
  // constants refused
  if (FRAME_WAIT_EXP > pcbp_pkg::FWI_MAX) begin : g_fwi
    $error("frame wait exponent above limit");
  end
  if ((pcbp_pkg::BIT_RATE & pcbp_pkg::RATE_FC32) != pcbp_pkg::RATE_FC32) begin : g_rate
    $error("bit rate lacks fc/32");
  end
  if (pcbp_pkg::FSCI < pcbp_pkg::FSCI_MIN) begin : g_fsci
    $error("frame size below 256");
  end
  if (pcbp_pkg::AFC != 8'h00 || pcbp_pkg::ADC != 2'h0) begin : g_afc
    $error("family code or coding not zero");
  end

  // Granted multiplier ceiling so that the extended wait stays in bounds
  localparam int LIM_I = 1 << (int'(pcbp_pkg::FWI_MAX) - int'(FRAME_WAIT_EXP));
  localparam logic [5:0] WTX_LIM = (LIM_I > 59) ? pcbp_pkg::WAIT_EXTENSION_MULTIPLIER_MAX : 6'(LIM_I);

  // ==========================================================
  // Functions
  function automatic logic agree(logic [2:0] s, logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction : agree

  function automatic logic [31:0] nextPupi(logic [31:0] p);
    logic [31:0] b;
    b = (p == 32'h00000000) ? pcbp_pkg::PSEUDO_UNIQUE_CARD_ID_INIT : p;
    return {b[30:0], 1'b0} ^ (b[31] ? pcbp_pkg::PSEUDO_UNIQUE_CARD_ID_POLY : 32'h00000000);
  endfunction : nextPupi

  function automatic logic [5:0] clampWtx(logic [5:0] m);
    if (m == 6'h00) return 6'h01;
    return (m > WTX_LIM) ? WTX_LIM : m;
  endfunction : clampWtx

  function automatic logic [7:0] pupiByte(logic [31:0] p, logic [8:0] i);
    case (i[2:0])
      3'h1: return p[31:24];
      3'h2: return p[23:16];
      3'h3: return p[15:8];
      default: return p[7:0];
    endcase
  endfunction : pupiByte

  // ==========================================================
  // State types
  typedef struct packed {
    logic seeded;
    logic [31:0] pseudo_unique_card_id;
    logic storeWr;
    logic wtxTgl;
    logic [5:0] wait_extension_multiplier;
    logic [2:0] ackS;
    logic ackV;
    logic [2:0] errS;
    logic errV;
    logic err;
    logic [2:0] actS;
    logic actV;
  } pcbp_sys_s;

  typedef struct packed {
    logic [2:0] rdyS;
    logic rdyV;
    logic [2:0] wtxS;
    logic wtxV;
    logic ackTgl;
    logic errTgl;
    pcbp_pkg::pcbp_lst_e st;
    logic act;
    logic [31:0] pseudo_unique_card_id;
    logic [8:0] cnt;
    logic [7:0] cmd;
    logic ok;
    logic [3:0] card_logical_id;
    logic [3:0] txLen;
    pcbp_pkg::pcbp_kind_e kind;
    logic [11:0][7:0] buff;
  } pcbp_lnk_s;

  pcbp_sys_s sq;
  pcbp_sys_s sd;
  pcbp_lnk_s lq;
  pcbp_lnk_s ld;
  logic [2:0] rstS;
  logic lnkRst;

  // ==========================================================
  // System domain
  always_comb
  begin
    sd = sq;
    sd.storeWr = 1'b0;
    if (!sq.seeded)
    begin
      sd.seeded = 1'b1;
      sd.pseudo_unique_card_id = nextPupi(pupiSeed);
      sd.storeWr = 1'b1;
    end
    sd.ackS = {sq.ackS[1:0], lq.ackTgl};
    sd.ackV = agree(sq.ackS, sq.ackV);
    sd.errS = {sq.errS[1:0], lq.errTgl};
    sd.errV = agree(sq.errS, sq.errV);
    sd.err = sd.errV != sq.errV;
    sd.actS = {sq.actS[1:0], lq.act};
    sd.actV = agree(sq.actS, sq.actV);
    if (wtxReq && !wtxBusy)
    begin
      sd.wtxTgl = ~sq.wtxTgl;
      sd.wait_extension_multiplier = clampWtx(wtxMult);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sq <= '0;
    else
      sq <= sd;
  end

  assign pupiStore = sq.pseudo_unique_card_id;
  assign pupiStoreWr = sq.storeWr;
  assign wtxBusy = sq.wtxTgl != sq.ackV;
  assign wtxGranted = sq.wait_extension_multiplier;
  assign protoErr = sq.err;
  assign sessionActive = sq.actV;

  // ==========================================================
  // Link domain reset, released only once two stages agree
  always_ff @(posedge clkLink)
  begin
    rstS <= {rstS[1:0], sys_rst};
    lnkRst <= agree(rstS, lnkRst);
  end

  // ==========================================================
  // Link domain
  // Sys words cross stable: they never change while their flag is held.
  always_comb
  begin
    ld = lq;
    ld.rdyS = {lq.rdyS[1:0], sq.seeded};
    ld.rdyV = agree(lq.rdyS, lq.rdyV);
    ld.wtxS = {lq.wtxS[1:0], sq.wtxTgl};
    ld.wtxV = agree(lq.wtxS, lq.wtxV);
    if (lq.st == pcbp_pkg::LS_WAIT && lq.rdyV)
    begin
      ld.pseudo_unique_card_id = sq.pseudo_unique_card_id;
      ld.st = pcbp_pkg::LS_READY;
    end
    if (lq.txLen != 4'h0 && lnkTxReady)
    begin
      ld.buff = {lq.buff[10:0], 8'h00};
      ld.txLen = lq.txLen - 4'h1;
    end
    if (lnkRx.valid)
    begin
      ld.cnt = (lq.cnt == pcbp_pkg::CNT_SAT) ? lq.cnt : lq.cnt + 9'h001;
      if (lq.cnt == pcbp_pkg::FRAME_MAX)
        ld.errTgl = ~lq.errTgl;
      if (lq.cnt == 9'h000)
      begin
        ld.cmd = lnkRx.data;
        ld.ok = 1'b1;
      end
      if (lq.st == pcbp_pkg::LS_READY)
      begin
        if (lq.cnt == 9'h001 && lq.cmd == pcbp_pkg::CMD_REQ)
          ld.ok = lnkRx.data == pcbp_pkg::AFC;
        else if (lq.cnt >= 9'h001 && lq.cnt <= 9'h004 && lq.cmd == pcbp_pkg::CMD_ATTR)
          ld.ok = lq.ok && (lnkRx.data == pupiByte(lq.pseudo_unique_card_id, lq.cnt));
        if (lq.cnt == 9'h008)
          ld.card_logical_id = lnkRx.data[3:0];
      end
      if (lq.st == pcbp_pkg::LS_ACTIVE && lq.cnt == 9'h001 && lq.cmd[pcbp_pkg::CID_FLAG]
          && (lnkRx.data & pcbp_pkg::CID_RSV) != 8'h00)
        ld.errTgl = ~lq.errTgl;
      if (lnkRx.last)
      begin
        ld.cnt = 9'h000;
        if (lq.st == pcbp_pkg::LS_READY && lq.cmd == pcbp_pkg::CMD_REQ && lq.ok
            && lq.cnt == 9'h002)
        begin
          ld.buff = {pcbp_pkg::ATQB_HDR, lq.pseudo_unique_card_id, pcbp_pkg::AFC, pcbp_pkg::AID_CRC,
                     pcbp_pkg::APP_CNT, pcbp_pkg::BIT_RATE,
                     pcbp_pkg::FSCI, pcbp_pkg::PROT_TYPE,
                     FRAME_WAIT_EXP, pcbp_pkg::ADC, pcbp_pkg::FOPT};
          ld.txLen = pcbp_pkg::ATQB_LEN;
          ld.kind = pcbp_pkg::TK_ATQB;
        end
        if (lq.st == pcbp_pkg::LS_READY && lq.cmd == pcbp_pkg::CMD_ATTR && lq.ok
            && lq.cnt >= 9'h008)
        begin
          ld.buff = {pcbp_pkg::MAX_BUFFER_LENGTH_INDEX, ld.card_logical_id, 88'h0};
          ld.txLen = pcbp_pkg::ATTR_LEN;
          ld.kind = pcbp_pkg::TK_ATTR;
          ld.st = pcbp_pkg::LS_ACTIVE;
        end
      end
    end
    else if (lq.wtxV != lq.ackTgl && lq.txLen == 4'h0 && lq.cnt == 9'h000)
    begin
      // Requests outside a session are acknowledged and dropped
      ld.ackTgl = lq.wtxV;
      if (lq.st == pcbp_pkg::LS_ACTIVE)
      begin
        ld.buff = {pcbp_pkg::PCB_WTX, 4'h0, lq.card_logical_id, pcbp_pkg::PLI, sq.wait_extension_multiplier, 72'h0};
        ld.txLen = pcbp_pkg::WTX_LEN;
        ld.kind = pcbp_pkg::TK_WTX;
      end
    end
    ld.act = ld.st == pcbp_pkg::LS_ACTIVE;
  end

  always_ff @(posedge clkLink)
  begin
    if (lnkRst)
      lq <= '0;
    else
      lq <= ld;
  end

  assign lnkTx.valid = lq.txLen != 4'h0;
  assign lnkTx.last = lq.txLen == 4'h1;
  assign lnkTx.data = lq.buff[11];

  // ==========================================================
  // Checks
  property p_afc;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_ATQB && lq.txLen == 4'h7
      |-> lnkTx.data == 8'h00;
  endproperty
  a_afc: assert property (p_afc) else $error("family code not zero");

  property p_rate;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_ATQB && lq.txLen == 4'h3
      |-> (lnkTx.data & 8'h22) == 8'h22;
  endproperty
  a_rate: assert property (p_rate) else $error("fc/32 not advertised");

  property p_prot;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_ATQB && lq.txLen == 4'h2
      |-> lnkTx.data[3:0] == 4'h1 && lnkTx.data[7:4] >= 4'h8;
  endproperty
  a_prot: assert property (p_prot) else $error("protocol info wrong");

  property p_fwi;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_ATQB && lnkTx.last
      |-> lnkTx.data[7:4] <= 4'hc && lnkTx.data[3:2] == 2'h0;
  endproperty
  a_fwi: assert property (p_fwi) else $error("wait exponent or coding wrong");

  property p_fopt;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_ATQB && lnkTx.last
      |-> lnkTx.data[1:0] == 2'h1;
  endproperty
  a_fopt: assert property (p_fopt) else $error("frame option wrong");

  property p_ovf;
    @(posedge clkLink) disable iff (lnkRst)
    lnkRx.valid && lq.cnt == 9'h100 |=> lq.errTgl != $past(lq.errTgl);
  endproperty
  a_ovf: assert property (p_ovf) else $error("oversize frame not flagged");

  property p_cid;
    @(posedge clkLink) disable iff (lnkRst)
    lnkRx.valid && lq.st == pcbp_pkg::LS_ACTIVE && lq.cnt == 9'h001 && lq.cmd[3]
      && lnkRx.data[6:5] != 2'h0 |=> lq.errTgl != $past(lq.errTgl);
  endproperty
  a_cid: assert property (p_cid) else $error("reserved id bits not flagged");

  property p_wtx;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_WTX && lnkTx.last
      |-> lnkTx.data[7:6] == 2'h0 && lnkTx.data[5:0] != 6'h00
        && lnkTx.data[5:0] <= WTX_LIM;
  endproperty
  a_wtx: assert property (p_wtx) else $error("extension out of bounds");

  property p_max_buffer_length_index;
    @(posedge clkLink) disable iff (lnkRst)
    lnkTx.valid && lq.kind == pcbp_pkg::TK_ATTR |-> lnkTx.data[7:4] == 4'h0;
  endproperty
  a_max_buffer_length_index: assert property (p_max_buffer_length_index) else $error("buffer index reported");

  property p_pseudo_unique_card_id;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(sq.seeded) |-> sq.pseudo_unique_card_id != $past(pupiSeed) && pupiStoreWr;
  endproperty
  a_pseudo_unique_card_id: assert property (p_pseudo_unique_card_id) else $error("identifier repeated");

  sequence s_take;
    wtxReq && !wtxBusy;
  endsequence
  sequence s_hold;
    (wtxBusy && wtxGranted != 6'h00 && wtxGranted <= WTX_LIM) [*3];
  endsequence
  property p_take;
    @(posedge clk_sys) disable iff (sys_rst)
    s_take |=> s_hold;
  endproperty
  a_take: assert property (p_take) else $error("extension grant wrong");

endmodule : pcbp_profile

// ===== pcbp_reader_model.sv
`timescale 1ns/10ps

// ==========================================================
// Reader at the far side of the link
module pcbp_reader_model (
  input wire logic clkLink,
  output pcbp_pkg::pcbp_byte_s lnkRx,
  input wire pcbp_pkg::pcbp_byte_s lnkTx,
  output logic lnkTxReady
);
  logic [7:0] txQ[$];
  logic [7:0] rxQ[$];
  logic slow = 1'b0;
  logic linkErr = 1'b0;

  initial lnkRx = '{valid: 1'b0, last: 1'b0, data: 8'h00};
  initial lnkTxReady = 1'b1;

  // Slow mode stalls every other cycle
  always @(negedge clkLink) lnkTxReady <= slow ? ~lnkTxReady : 1'b1;

  always @(posedge clkLink)
  begin
    if (lnkTx.valid === 1'b1 && lnkTxReady === 1'b1)
    begin
      rxQ.push_back(lnkTx.data);
      if (rxQ.size() == 3 && rxQ[0] == pcbp_pkg::PCB_WTX
          && (rxQ[2][5:0] == 6'h00 || rxQ[2][5:0] > pcbp_pkg::WAIT_EXTENSION_MULTIPLIER_MAX))
        linkErr <= 1'b1;
      if (rxQ.size() == 2 && rxQ[0][3] && rxQ[1][6:5] != 2'h0)
        linkErr <= 1'b1;
    end
  end

  // Idle data shows the inverse, never a stale byte
  task automatic send();
    int n;
    n = txQ.size();
    for (int i = 0; i < n; i++)
    begin
      @(negedge clkLink);
      lnkRx <= '{valid: 1'b1, last: (i == n - 1), data: txQ[i]};
    end
    @(negedge clkLink);
    lnkRx <= '{valid: 1'b0, last: 1'b0, data: ~lnkRx.data};
    txQ.delete();
  endtask : send
endmodule : pcbp_reader_model

// ===== tb_pcbp_profile.sv
`timescale 1ns/10ps

// ==========================================================
// Bench
module tb_pcbp_profile;
  // Small exponent so clamping shows a limit of 16
  localparam logic [3:0] FWE = 4'h8;
  localparam logic [31:0] SEED = 32'h1234abcd;
  logic [31:0] pupiSeed = SEED;
  logic clk_sys = 1'b0;
  logic clkLink = 1'b0;
  logic sys_rst = 1'b1;
  logic wtxReq = 1'b0;
  logic [5:0] wtxMult = 6'h00;
  logic pupiStoreWr, wtxBusy, protoErr, sessionActive, lnkTxReady;
  logic [31:0] pupiStore;
  logic [31:0] cardId;
  logic [5:0] wtxGranted;
  pcbp_pkg::pcbp_byte_s lnkRx, lnkTx;
  int err_count = 0;
  int n_tests = 0;

  initial forever #4 clk_sys = ~clk_sys;
  initial
  begin
    #7;
    forever #15 clkLink = ~clkLink;
  end

  pcbp_profile #(.FRAME_WAIT_EXP(FWE)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clkLink(clkLink), .pupiSeed(pupiSeed), .pupiStore(pupiStore), .pupiStoreWr(pupiStoreWr),
    .wtxReq(wtxReq), .wtxMult(wtxMult), .wtxBusy(wtxBusy), .wtxGranted(wtxGranted),
    .protoErr(protoErr), .sessionActive(sessionActive), .lnkRx(lnkRx), .lnkTx(lnkTx),
    .lnkTxReady(lnkTxReady));

  pcbp_reader_model rdr (.clkLink(clkLink), .lnkRx(lnkRx), .lnkTx(lnkTx),
    .lnkTxReady(lnkTxReady));

  // ==========================================================
  // Helpers
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic expectRx(input logic [7:0] exp [$], input string msg);
    for (int i = 0; i < 2000 && rdr.rxQ.size() < exp.size(); i++) @(posedge clk_sys);
    check(rdr.rxQ.size() == exp.size(), msg);
    foreach (exp[i]) check(rdr.rxQ[i] === exp[i], msg);
    rdr.rxQ.delete();
  endtask : expectRx

  task automatic watchErr(input int n, output logic seen);
    seen = 1'b0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (protoErr === 1'b1) seen = 1'b1;
    end
  endtask : watchErr

  // ==========================================================
  // Scenarios
  task automatic t_reqb();
    // Family code 01 refused, slot count one
    rdr.txQ = '{pcbp_pkg::CMD_REQ, 8'h01, 8'h00};
    rdr.send();
    repeat (60) @(negedge clk_sys);
    check(rdr.rxQ.size() == 0, "answer to foreign family");
    rdr.slow = 1'b1;
    rdr.txQ = '{pcbp_pkg::CMD_REQ, 8'h00, 8'h00};
    rdr.send();
    expectRx('{8'h50, cardId[31:24], cardId[23:16], cardId[15:8], cardId[7:0],
      8'h00, 8'h00, 8'h00, 8'h00,
      8'h33, 8'h81, {FWE, 2'h0, 2'h1}}, "answer bytes");
    rdr.slow = 1'b0;
  endtask : t_reqb

  task automatic t_attrib();
    rdr.txQ = '{pcbp_pkg::CMD_ATTR, cardId[31:24], cardId[23:16], cardId[15:8], ~cardId[7:0],
      8'h00, 8'h08, 8'h01, 8'h03};
    rdr.send();
    repeat (60) @(negedge clk_sys);
    check(rdr.rxQ.size() == 0 && sessionActive === 1'b0, "foreign id accepted");
    rdr.txQ = '{pcbp_pkg::CMD_ATTR, cardId[31:24], cardId[23:16], cardId[15:8], cardId[7:0],
      8'h00, 8'h08, 8'h01, 8'h03};
    rdr.send();
    expectRx('{8'h03}, "attrib answer");
    repeat (20) @(negedge clk_sys);
    check(sessionActive === 1'b1, "session not active");
    // Requests are ignored once a session runs
    rdr.txQ = '{pcbp_pkg::CMD_REQ, 8'h00, 8'h00};
    rdr.send();
    repeat (60) @(negedge clk_sys);
    check(rdr.rxQ.size() == 0, "answer to request in session");
  endtask : t_attrib

  task automatic t_frame(input int n, input logic [7:0] cidByte, input logic expErr);
    logic seen;
    rdr.txQ = '{8'h0a, cidByte};
    while (rdr.txQ.size() < n) rdr.txQ.push_back(8'h5a);
    fork
      rdr.send();
      watchErr(n * 4 + 60, seen);
    join
    check(seen === expErr, "protocol error flag");
    rdr.rxQ.delete();
  endtask : t_frame

  task automatic t_wtx(input logic [5:0] mult, input logic [5:0] expG);
    @(negedge clk_sys);
    wtxReq = 1'b1;
    wtxMult = mult;
    @(negedge clk_sys);
    wtxReq = 1'b0;
    check(wtxBusy === 1'b1 && wtxGranted === expG, "wait grant");
    for (int i = 0; i < 400 && wtxBusy !== 1'b0; i++) @(negedge clk_sys);
    check(wtxBusy === 1'b0, "wait ack");
    expectRx('{pcbp_pkg::PCB_WTX, 8'h03, {2'h0, expG}}, "wait frame");
  endtask : t_wtx

  task automatic t_power();
    // Power cycle after a session; the store hands back the last id
    @(negedge clk_sys);
    sys_rst = 1'b1;
    pupiSeed = cardId;
    repeat (25) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    check(pupiStoreWr === 1'b1 && pupiStore !== cardId, "id repeated after power-off");
    cardId = pupiStore;
    check(sessionActive === 1'b0 && wtxBusy === 1'b0, "state survived power-off");
    repeat (80) @(negedge clk_sys);
    // Extension outside a session is acknowledged, nothing sent
    wtxReq = 1'b1;
    wtxMult = 6'h05;
    @(negedge clk_sys);
    wtxReq = 1'b0;
    for (int i = 0; i < 400 && wtxBusy !== 1'b0; i++) @(negedge clk_sys);
    repeat (60) @(negedge clk_sys);
    check(wtxBusy === 1'b0 && rdr.rxQ.size() == 0, "extension outside session");
    t_reqb();
  endtask : t_power

  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ==========================================================
  // Main sequence; reset spans six link cycles
  initial
  begin
    repeat (25) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    check(pupiStoreWr === 1'b1 && pupiStore !== SEED, "new card id");
    cardId = pupiStore;
    @(negedge clk_sys);
    check(pupiStoreWr === 1'b0, "id store pulse");
    repeat (80) @(negedge clk_sys);
    t_reqb();
    t_attrib();
    t_frame(3, 8'h23, 1'b1);
    t_frame(3, 8'h03, 1'b0);
    t_frame(256, 8'h03, 1'b0);
    t_frame(257, 8'h03, 1'b1);
    t_wtx(6'h00, 6'h01);
    t_wtx(6'h3f, 6'h10);
    t_wtx(6'h0a, 6'h0a);
    t_power();
    check(rdr.linkErr === 1'b0, "link error at reader");
    conclude();
  end

  initial
  begin
    #150000;
    err_count++;
    $display("ERROR at %0t: watchdog", $time);
    conclude();
  end
endmodule : tb_pcbp_profile
